// ### logic/tcc_timer.sv
// three-channel 16-bit capture/compare timer with an AXI4-Lite register slave
// Functional notes
// R1: three channels, each a 16-bit up-counter
// R2: per-channel clock: div 1/2/4/8 or four pins
// R3: two general registers, compare or capture each
// R4: match drives pin low/high/toggle; no toggle ch2
// R5: capture on rising, falling or both edges
// R6: counter cleared by match or capture
// R7: synchronized channels preset and clear together
// R8: PWM output with software duty, three-phase synced
// R9: PWM waveform on pin A; else register A
// R10: channel 2 phase counting from clock pins A/B
// R11: three individually enabled interrupt requests per channel
// R12: match and capture events drive pattern triggers
// R13: software sets initial output pin levels
// R14: counters and registers accessed as 16-bit words
// R15: channels 0 and 1 identical; 2 differs little
// R16: run bit halts counter; zero after reset
// R17: sync bit puts channel in synchronized group
// R18: count per selected edge; wrap sets overflow (clock pins count rising edges only; no overflow flag in phase counting)
// R19: match when counter equals compare register value
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`include "tcc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tcc_timer #(
  parameter int CHANNELS = 3
) (
  input wire logic aclk, // 50 MHz clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic ext_clock_in_a, // external clock a, phase a
  input wire logic ext_clock_in_b, // external clock b, phase b
  input wire logic ext_clock_in_c, // external clock c
  input wire logic ext_clock_in_d, // external clock d
  input wire logic [2:0] chan_pin_a_i, // pin a input level
  output logic [2:0] chan_pin_a_o, // pin a output level
  output logic [2:0] chan_pin_a_oe, // pin a output enable
  input wire logic [2:0] chan_pin_b_i, // pin b input level
  output logic [2:0] chan_pin_b_o, // pin b output level
  output logic [2:0] chan_pin_b_oe, // pin b output enable
  output logic [5:0] pattern_trigger, // match/capture pulses to pattern_output_controller
  output logic irq // level interrupt
);
  if (CHANNELS != 3) begin : g_bad_channels
    $error("tcc_timer supports exactly three channels");
  end

  // ---- synchronisers for every pin input
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic [9:0] pin_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 10'h000;
      pin_sync <= 10'h000;
      pin_prev <= 10'h000;
    end else begin
      pin_meta <= {chan_pin_b_i, chan_pin_a_i, ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  logic [9:0] pin_rise;
  logic [9:0] pin_fall;
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // ---- prescaler: one-cycle enables at clk/2, /4, /8
  logic [2:0] presc;
  always_ff @(posedge aclk) begin
    if (!aresetn) presc <= 3'h0;
    else presc <= presc + 3'h1;
  end
  logic [7:0] tick_src;
  assign tick_src = {pin_rise[3:0], presc == 3'h7, presc[1:0] == 2'h3, presc[0], 1'b1}; // R2

  // ---- registers
  logic [2:0] run;
  logic [2:0] sync_en;
  logic [3:0] mode; // bits 2:0 pwm per channel, bit 3 phase counting on channel 2
  logic [5:0] olvl;
  logic [8:0] stat;
  logic [8:0] mask;
  tcc_pkg::tcc_ctrl_t ctrl [3];
  logic [7:0] ioc [3];
  logic [15:0] cnt [3];
  logic [15:0] gen_a [3];
  logic [15:0] gen_b [3];

  // ---- AXI4-Lite write path: address and data taken in either order
  logic wr_hit;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write decode; channel window: base + ch*stride + offset
  logic [1:0] wr_ch;
  logic wr_in_ch;
  logic lo_en;
  logic hw_en;
  assign wr_in_ch = aw_addr >= `TCC_OFF_CH_BASE && aw_addr < (`TCC_OFF_CH_BASE + 8'h30);
  assign wr_ch = 2'((aw_addr - `TCC_OFF_CH_BASE) >> 4);
  assign lo_en = w_strb[0];
  assign hw_en = w_strb[1:0] == 2'h3; // 16-bit registers only change as whole words
  assign wr_hit = wr_in_ch || aw_addr == `TCC_OFF_RUN || aw_addr == `TCC_OFF_SYNC || aw_addr == `TCC_OFF_MODE ||
                  aw_addr == `TCC_OFF_OLVL || aw_addr == `TCC_OFF_STAT || aw_addr == `TCC_OFF_MASK;
  logic wr_cnt_any;
  logic [2:0] wr_cnt_ch;
  logic [2:0] wr_cnt_eff;
  logic [2:0] wr_gen_ch;
  logic [2:0] wr_ctl_ch;
  always_comb begin
    wr_cnt_ch = 3'h0;
    wr_gen_ch = 3'h0;
    wr_ctl_ch = 3'h0;
    if (wr_go && wr_in_ch) begin
      if (aw_addr[3:0] == `TCC_OFF_CNT && hw_en) wr_cnt_ch[wr_ch] = 1'b1; // R14
      if (aw_addr[3:0] == `TCC_OFF_GEN && w_strb == 4'hf) wr_gen_ch[wr_ch] = 1'b1; // R14
      if (aw_addr[3:0] == `TCC_OFF_CTRL && lo_en) wr_ctl_ch[wr_ch] = 1'b1;
    end
  end
  assign wr_cnt_any = |(wr_cnt_ch & sync_en);
  // a preset written to any synchronized counter reaches the whole group
  assign wr_cnt_eff = wr_cnt_ch | (wr_cnt_any ? sync_en : 3'h0); // R7

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= `TCC_RST_RUN; // R16
      sync_en <= `TCC_RST_SYNC;
      mode <= `TCC_RST_MODE;
      mask <= 9'h000;
    end else if (wr_go && lo_en) begin
      if (aw_addr == `TCC_OFF_RUN) run <= w_data[2:0]; // R16
      if (aw_addr == `TCC_OFF_SYNC) sync_en <= w_data[2:0]; // R17
      if (aw_addr == `TCC_OFF_MODE) mode <= w_data[3:0];
      if (aw_addr == `TCC_OFF_MASK) mask <= {w_strb[1] ? w_data[8] : mask[8], w_data[7:0]}; // R11
    end
  end

  // ---- channel logic
  logic [2:0] tick;
  logic [2:0] match_a;
  logic [2:0] match_b;
  logic [2:0] cap_a;
  logic [2:0] cap_b;
  logic [2:0] clr_req;
  logic [2:0] ovf;
  logic [5:0] pin_lvl;
  logic sync_clr;
  assign sync_clr = |(clr_req & sync_en);

  // phase decoding for channel 2: quadrature on synced clock pins a/b
  logic ph_step;
  logic ph_up;
  assign ph_step = pin_rise[0] | pin_fall[0] | pin_rise[1] | pin_fall[1]; // R10
  assign ph_up = (pin_rise[0] | pin_fall[0]) ? (pin_sync[0] ^ pin_sync[1]) : ~(pin_sync[0] ^ pin_sync[1]);

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_ch // R1 R15
      logic phase_on;
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic pwm;
      logic edg_a;
      logic edg_b;
      logic clr_own;
      logic clr_now;
      assign phase_on = (c == 2) && mode[`TCC_MODE_PHASE_BIT];
      assign pwm = mode[c];
      // toggle is not built on channel 2: it degrades to action 0, so a match drives the pin low
      assign act_a = (c == 2 && ioc[c][1:0] == 2'h3) ? 2'h0 : ioc[c][1:0]; // R4
      assign act_b = (c == 2 && ioc[c][5:4] == 2'h3) ? 2'h0 : ioc[c][5:4]; // R4
      assign tick[c] = run[c] && (phase_on ? ph_step : tick_src[ctrl[c].clk]); // R2 R16
      // qualified by the tick: a slow clock would otherwise repeat the match every cycle
      assign match_a[c] = tick[c] && (pwm || !ioc[c][2]) && cnt[c] == gen_a[c]; // R19
      assign match_b[c] = tick[c] && (pwm || !ioc[c][6]) && cnt[c] == gen_b[c]; // R19
      always_comb begin
        unique case (ctrl[c].edge_sel) // R5
          2'b00: edg_a = pin_rise[4+c];
          2'b01: edg_a = pin_fall[4+c];
          default: edg_a = pin_rise[4+c] | pin_fall[4+c];
        endcase
        unique case (ctrl[c].edge_sel)
          2'b00: edg_b = pin_rise[7+c];
          2'b01: edg_b = pin_fall[7+c];
          default: edg_b = pin_rise[7+c] | pin_fall[7+c];
        endcase
      end
      assign cap_a[c] = !pwm && ioc[c][2] && edg_a; // R3 R9
      assign cap_b[c] = !pwm && ioc[c][6] && edg_b; // R3
      assign clr_req[c] = (ctrl[c].clr == 2'(tcc_pkg::TCC_CLR_A) && (match_a[c] || cap_a[c])) ||
                          (ctrl[c].clr == 2'(tcc_pkg::TCC_CLR_B) && (match_b[c] || cap_b[c])); // R6
      assign clr_own = clr_req[c] && !sync_en[c];
      // clear-by-sync follows a clear raised by any other synchronized channel
      assign clr_now = clr_own || (sync_en[c] && sync_clr) ||
                       (ctrl[c].clr == 2'(tcc_pkg::TCC_CLR_SYNC) && sync_en[c] && sync_clr); // R7
      assign ovf[c] = tick[c] && !phase_on && cnt[c] == 16'hffff; // R18

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt[c] <= `TCC_RST_CNT;
        end else if (wr_cnt_eff[c]) begin
          cnt[c] <= w_data[15:0]; // R7 R14
        end else if (clr_now) begin
          cnt[c] <= 16'h0000; // R6
        end else if (tick[c]) begin
          if (phase_on && !ph_up) cnt[c] <= cnt[c] - 16'h0001; // R10
          else cnt[c] <= cnt[c] + 16'h0001; // R18
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          gen_a[c] <= `TCC_RST_GEN;
          gen_b[c] <= `TCC_RST_GEN;
        end else begin
          if (cap_a[c]) gen_a[c] <= cnt[c]; // R5
          else if (wr_gen_ch[c]) gen_a[c] <= w_data[15:0];
          if (cap_b[c]) gen_b[c] <= cnt[c]; // R5
          else if (wr_gen_ch[c]) gen_b[c] <= w_data[31:16];
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl[c] <= `TCC_RST_CTRL;
          ioc[c] <= `TCC_RST_IOC;
        end else begin
          if (wr_ctl_ch[c]) ctrl[c] <= w_data[6:0];
          if (wr_go && wr_in_ch && wr_ch == 2'(c) && aw_addr[3:0] == `TCC_OFF_IOC && lo_en) ioc[c] <= w_data[7:0];
        end
      end

      // pin levels: initial level write, then match actions or pwm
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_lvl[c] <= 1'b0;
          pin_lvl[3+c] <= 1'b0;
        end else if (wr_go && lo_en && aw_addr == `TCC_OFF_OLVL && run[c] == 1'b0) begin
          pin_lvl[c] <= w_data[c]; // R13
          pin_lvl[3+c] <= w_data[3+c]; // R13
        end else if (pwm) begin
          // high from match a, low at match b: duty set by general_reg_a/general_reg_b
          if (match_b[c]) pin_lvl[c] <= 1'b0; // R8 R9
          else if (match_a[c]) pin_lvl[c] <= 1'b1; // R8
        end else begin
          if (match_a[c]) pin_lvl[c] <= act_a == 2'h3 ? ~pin_lvl[c] : act_a[1]; // R4 R19
          if (match_b[c]) pin_lvl[3+c] <= act_b == 2'h3 ? ~pin_lvl[3+c] : act_b[1]; // R4
        end
      end
      assign chan_pin_a_oe[c] = pwm || (!ioc[c][2] && ioc[c][1:0] != 2'h0); // R9
      assign chan_pin_b_oe[c] = !pwm && !ioc[c][6] && ioc[c][5:4] != 2'h0;
    end
  endgenerate
  assign chan_pin_a_o = pin_lvl[2:0];
  assign chan_pin_b_o = pin_lvl[5:3];

  // ---- events, status and interrupt; set wins over write-one-to-clear
  logic [8:0] evt;
  assign evt = {ovf[2], match_b[2] | cap_b[2], match_a[2] | cap_a[2],
                ovf[1], match_b[1] | cap_b[1], match_a[1] | cap_a[1],
                ovf[0], match_b[0] | cap_b[0], match_a[0] | cap_a[0]};
  logic [8:0] stat_clr;
  assign stat_clr = (wr_go && aw_addr == `TCC_OFF_STAT) ?
                    {w_data[8] & w_strb[1], w_data[7:0] & {8{w_strb[0]}}} : 9'h000;
  always_ff @(posedge aclk) begin
    if (!aresetn) stat <= 9'h000;
    else stat <= (stat & ~stat_clr) | evt; // R11 R18
  end
  assign irq = |(stat & mask); // R11

  always_ff @(posedge aclk) begin
    if (!aresetn) pattern_trigger <= 6'h00;
    else pattern_trigger <= {evt[7], evt[6], evt[4], evt[3], evt[1], evt[0]}; // R12
  end

  // ---- AXI4-Lite read path
  logic [31:0] rd_val;
  logic rd_ok;
  logic [1:0] rd_ch;
  assign rd_ch = 2'((s_axi_araddr - `TCC_OFF_CH_BASE) >> 4);
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr >= `TCC_OFF_CH_BASE && s_axi_araddr < (`TCC_OFF_CH_BASE + 8'h30)) begin
      unique case (s_axi_araddr[3:0])
        `TCC_OFF_CTRL: rd_val = {25'h0, ctrl[rd_ch]};
        `TCC_OFF_IOC: rd_val = {24'h0, ioc[rd_ch]};
        `TCC_OFF_CNT: rd_val = {16'h0, cnt[rd_ch]};
        `TCC_OFF_GEN: rd_val = {gen_b[rd_ch], gen_a[rd_ch]};
        default: rd_ok = 1'b0;
      endcase
    end else begin
      unique case (s_axi_araddr)
        `TCC_OFF_RUN: rd_val = {29'h0, run};
        `TCC_OFF_SYNC: rd_val = {29'h0, sync_en};
        `TCC_OFF_MODE: rd_val = {28'h0, mode};
        `TCC_OFF_OLVL: rd_val = {26'h0, pin_lvl};
        `TCC_OFF_STAT: rd_val = {23'h0, stat};
        `TCC_OFF_MASK: rd_val = {23'h0, mask};
        default: rd_ok = 1'b0;
      endcase
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : tcc_timer
`default_nettype wire

// ### logic/tcc_regs.svh
// register offsets, field positions and reset values of the capture/compare timer
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_OFF_RUN 8'h00
`define TCC_OFF_SYNC 8'h04
`define TCC_OFF_MODE 8'h08
`define TCC_OFF_OLVL 8'h0c
`define TCC_OFF_STAT 8'h10
`define TCC_OFF_MASK 8'h14
`define TCC_OFF_CH_BASE 8'h20
`define TCC_CH_STRIDE 8'h10
`define TCC_OFF_CTRL 4'h0
`define TCC_OFF_IOC 4'h4
`define TCC_OFF_CNT 4'h8
`define TCC_OFF_GEN 4'hc
`define TCC_RST_RUN 3'h0
`define TCC_RST_SYNC 3'h0
`define TCC_RST_MODE 4'h0
`define TCC_RST_CNT 16'h0000
`define TCC_RST_GEN 16'hffff
`define TCC_RST_IOC 8'h00
`define TCC_RST_CTRL 7'h00
`define TCC_CTRL_CLK_LSB 0
`define TCC_CTRL_CLR_LSB 3
`define TCC_CTRL_EDGE_LSB 5
`define TCC_IOC_B_LSB 4
`define TCC_MODE_PHASE_BIT 3
`endif

// ### logic/tcc_pkg.sv
// types shared by the capture/compare timer
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_CLK_DIV1 = 3'b000,
    TCC_CLK_DIV2 = 3'b001,
    TCC_CLK_DIV4 = 3'b010,
    TCC_CLK_DIV8 = 3'b011,
    TCC_CLK_EXTA = 3'b100,
    TCC_CLK_EXTB = 3'b101,
    TCC_CLK_EXTC = 3'b110,
    TCC_CLK_EXTD = 3'b111
  } tcc_clk_t;
  typedef enum logic [1:0] {
    TCC_CLR_NONE = 2'b00,
    TCC_CLR_A = 2'b01,
    TCC_CLR_B = 2'b10,
    TCC_CLR_SYNC = 2'b11
  } tcc_clr_t;
  typedef enum logic [1:0] {
    TCC_EDGE_RISE = 2'b00,
    TCC_EDGE_FALL = 2'b01,
    TCC_EDGE_BOTH = 2'b10,
    TCC_EDGE_RSV = 2'b11
  } tcc_edge_t;
  // io control nibble: bit2 = capture, bits1:0 = compare action (0 none, 1 low, 2 high, 3 toggle)
  typedef struct packed {
    logic capture;
    logic [1:0] action;
  } tcc_ioc_t;
  typedef struct packed {
    logic [1:0] edge_sel;
    logic [1:0] clr;
    logic [2:0] clk;
  } tcc_ctrl_t;
  typedef struct packed {
    logic ovf;
    logic evb;
    logic eva;
  } tcc_evt_t;
endpackage : tcc_pkg

// ### tb/tcc_timer_sva.sv
// handshake, reset and trigger checks of the capture/compare timer ports
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_sva (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low active
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [2:0] chan_pin_a_oe, // pin a enable
  input wire logic [5:0] pattern_trigger, // trigger pulses
  input wire logic irq // interrupt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  trig_pulse_a: assert property ((pattern_trigger & $past(pattern_trigger)) == 6'h00)
    else $error("trigger longer than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !irq && chan_pin_a_oe == 3'h0)
    else $error("outputs active after reset");
endmodule : tcc_timer_sva
bind tcc_timer tcc_timer_sva tcc_timer_sva_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .chan_pin_a_oe, .pattern_trigger, .irq);
`default_nettype wire

// ### tb/tcc_env_model.sv
// far-side model: pulse sources on the clock pins and levels on the capture pins
`timescale 1ns/1ns
`default_nettype none
module tcc_env_model (
  input wire logic aclk, // system clock
  input wire logic [2:0] a_o, // pin a level from timer
  input wire logic [2:0] a_oe, // pin a enable
  input wire logic [2:0] b_o, // pin b level from timer
  input wire logic [2:0] b_oe, // pin b enable
  output logic [3:0] ext_clk, // clock pins a..d
  output logic [2:0] a_i, // pin a wire level
  output logic [2:0] b_i // pin b wire level
);
  logic [2:0] a_drv = 3'h0;
  logic [2:0] b_drv = 3'h0;
  initial ext_clk = 4'h0;
  assign a_i = (a_oe & a_o) | (~a_oe & a_drv);
  assign b_i = (b_oe & b_o) | (~b_oe & b_drv);
  // levels held 4 cycles so the two-stage synchroniser cannot miss them
  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      ext_clk[pin] <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_clk[pin] <= 1'b0;
    end
  endtask : pulse
  // one encoder cycle, phase a leading phase b
  task automatic quad();
    for (int k = 0; k < 4; k++) begin
      repeat (4) @(posedge aclk);
      ext_clk[k % 2] <= ~ext_clk[k % 2];
    end
  endtask : quad
endmodule : tcc_env_model
`default_nettype wire

// ### tb/tcc_timer_test.sv
// self-checking bench of the capture/compare timer through its register bus
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [3:0] ext_clk;
  logic [2:0] chan_pin_a_i, chan_pin_a_o, chan_pin_a_oe, chan_pin_b_i, chan_pin_b_o, chan_pin_b_oe;
  logic [5:0] pattern_trigger, trig_seen = 6'h0;
  int errors = 0, compares = 0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) trig_seen <= aresetn ? (trig_seen | pattern_trigger) : 6'h0;
  tcc_timer tcc_timer_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_clock_in_a(ext_clk[0]), .ext_clock_in_b(ext_clk[1]), .ext_clock_in_c(ext_clk[2]),
    .ext_clock_in_d(ext_clk[3]), .chan_pin_a_i, .chan_pin_a_o, .chan_pin_a_oe, .chan_pin_b_i, .chan_pin_b_o,
    .chan_pin_b_oe, .pattern_trigger, .irq);
  tcc_env_model tcc_env_model_inst (.aclk, .a_o(chan_pin_a_o), .a_oe(chan_pin_a_oe), .b_o(chan_pin_b_o),
    .b_oe(chan_pin_b_oe), .ext_clk, .a_i(chan_pin_a_i), .b_i(chan_pin_b_i));
  function automatic logic [7:0] ca(input int c, input int o);
    return 8'(32'h20 + 16 * c + o);
  endfunction : ca
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a);
    chk($sformatf("reg %h", a), rd & m, e);
  endtask : rchk
  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    errors++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h7, 32'h0);
    rchk(8'h04, 32'h7, 32'h0);
    rchk(ca(0, 12), 32'hffffffff, 32'hffffffff);
    rchk(8'hfc, 32'hffffffff, 32'h0);
    chk("unmapped resp", last_resp, 32'h2);
    wr(8'hfc, 32'h0);
    chk("unmapped wresp", last_resp, 32'h2);
    wr(ca(0, 8), 32'h0000a5c3);
    chk("write resp", last_resp, 32'h0);
    rchk(ca(0, 8), 32'hffff, 32'ha5c3);
    wr(8'h04, 32'h3);
    wr(ca(0, 8), 32'h1234);
    rchk(ca(1, 8), 32'hffff, 32'h1234);
    rchk(ca(2, 8), 32'hffff, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h25);
    chk("level a", chan_pin_a_o, 32'h5);
    chk("level b", chan_pin_b_o, 32'h4);
    wr(8'h0c, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ca(0, 8), 32'h0);
      wr(ca(0, 0), 32'(4 + k));
      wr(8'h00, 32'h1);
      tcc_env_model_inst.pulse(k, 3);
      repeat (8) @(posedge aclk);
      wr(8'h00, 32'h0);
      rchk(ca(0, 8), 32'hffff, 32'h3);
    end
    // toggle on channel 1, channel 2 must ignore the toggle choice
    for (int c = 1; c < 3; c++) begin
      wr(ca(c, 8), 32'h0);
      wr(ca(c, 4), 32'h3);
      wr(ca(c, 12), 32'hffff0010);
    end
    wr(8'h00, 32'h6);
    repeat (60) @(posedge aclk);
    wr(8'h00, 32'h0);
    chk("toggle", chan_pin_a_o, 32'h2);
    rchk(8'h10, 32'h48, 32'h48);
    chk("trigger", trig_seen & 6'h14, 32'h14);
    wr(8'h10, 32'h1ff);
    wr(ca(0, 0), 32'h08);
    wr(ca(0, 4), 32'h02);
    wr(ca(0, 12), 32'hffff0020);
    wr(ca(0, 8), 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h1);
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge aclk);
    chk("irq a", irq, 32'h1);
    chk("high", chan_pin_a_o[0], 32'h1);
    repeat (50) @(posedge aclk);
    wr(8'h00, 32'h0);
    rd_reg(ca(0, 8));
    chk("cleared", rd[15:0] <= 16'h0020, 32'h1);
    wr(8'h10, 32'h1);
    chk("irq w1c", irq, 32'h0);
    wr(ca(0, 0), 32'h01);
    wr(ca(0, 4), 32'h0);
    wr(ca(0, 8), 32'hfff0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h1);
    repeat (80) @(posedge aclk);
    wr(8'h00, 32'h0);
    chk("irq masked", irq, 32'h0);
    rchk(8'h10, 32'h4, 32'h4);
    rd_reg(ca(0, 8));
    chk("wrapped", rd[15:0] < 16'h0030, 32'h1);
    wr(8'h14, 32'h4);
    chk("irq ovf", irq, 32'h1);
    wr(8'h10, 32'h1ff);
    chk("irq clear", irq, 32'h0);
    wr(ca(0, 0), 32'h20);
    wr(ca(0, 4), 32'h40);
    wr(8'h00, 32'h1);
    tcc_env_model_inst.b_drv[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    rchk(8'h10, 32'h2, 32'h0);
    tcc_env_model_inst.b_drv[0] <= 1'b0;
    repeat (10) @(posedge aclk);
    rchk(8'h10, 32'h2, 32'h2);
    wr(8'h00, 32'h0);
    chk("capture oe", chan_pin_b_oe[0], 32'h0);
    rd_reg(ca(0, 12));
    chk("captured", rd[31:16] != 16'hffff, 32'h1);
    wr(ca(0, 0), 32'h10);
    wr(ca(0, 4), 32'h0);
    wr(ca(0, 12), 32'h00400010);
    wr(ca(0, 8), 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 300 && chan_pin_a_o[0] !== 1'b1; n++) @(posedge aclk);
      chk("pwm high", {chan_pin_a_oe[0], chan_pin_a_o[0]}, 32'h3);
      for (int n = 0; n < 300 && chan_pin_a_o[0] !== 1'b0; n++) @(posedge aclk);
      chk("pwm low", chan_pin_a_o[0], 32'h0);
    end
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h8);
    wr(ca(2, 8), 32'h0);
    wr(8'h00, 32'h4);
    tcc_env_model_inst.quad();
    repeat (8) @(posedge aclk);
    wr(8'h00, 32'h0);
    rd_reg(ca(2, 8));
    chk("phase", rd[15:0], 32'h4);
    test_done();
  end
endmodule : tcc_timer_test
`default_nettype wire
